// ### design/display_ctrl_power_mode_sequencer.sv
// power-up reset sequencing and standby/active mode control
`timescale 1ns/1ps
`default_nettype none

module display_ctrl_power_mode_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYCLES,
  parameter int unsigned PARK_CYCLES = PARK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // power monitor pins
  input wire logic power_on_sense_i,
  input wire logic power_good_warning_n_i,
  // host command
  input wire mode_cmd_t mode_cmd_i,
  // status from the mirror array driver
  input wire logic mirror_array_parked_i,
  // domain controls
  output var domain_ctrl_t domain_ctrl_o,
  output logic mirror_array_park_o,
  output var func_mode_t mode_o,
  output logic cpu_booting_o
);

  // **********************************************************
  // input synchronisers
  // **********************************************************
  // shift one pin sample into a two-flop chain; logic reads bit 1 only
  function automatic logic [1:0] sync_shift(input logic [1:0] chain, input logic pin);
    sync_shift = {chain[0], pin};
  endfunction

  logic [1:0] sense_sync;
  logic [1:0] pgood_sync;
  logic sense_prev;
  logic [1:0] parked_sync;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sense_sync <= SYNC_RESET_VALUE;
      sense_prev <= 1'b0;
    end else begin
      sense_sync <= sync_shift(sense_sync, power_on_sense_i);
      sense_prev <= sense_sync[1];
    end
  end

  // the warning chain resets to its idle high level, so a reset never
  // looks like a supply loss for the two cycles the chain takes to fill
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pgood_sync <= ~SYNC_RESET_VALUE;
      parked_sync <= SYNC_RESET_VALUE;
    end else begin
      pgood_sync <= sync_shift(pgood_sync, power_good_warning_n_i);
      parked_sync <= sync_shift(parked_sync, mirror_array_parked_i);
    end
  end

  // sense_prev resets low: a pin already high at reset release restarts
  // the whole sequence, which is the intended behaviour of a system reset
  wire logic sense_high = sense_sync[1];
  wire logic sense_rise = sense_sync[1] && !sense_prev;
  wire logic supply_fail = !pgood_sync[1];
  wire logic parked = parked_sync[1];

  // **********************************************************
  // sequencer
  // **********************************************************
  seq_state_t state;
  seq_state_t next_state;
  logic [31:0] count;
  logic [31:0] next_count;
  func_mode_t mode;
  func_mode_t next_mode;

  wire logic lock_done = (count >= LOCK_CYCLES - 1);
  // park timeout guards against a driver that never reports parked
  wire logic park_done = parked || (count >= PARK_CYCLES - 1);

  always_comb begin
    next_state = state;
    next_count = count + 32'h1;
    case (state)
      ST_OFF: begin
        next_count = 32'h0;
        if (sense_rise) begin
          next_state = ST_PLL_WAIT;
        end
      end
      ST_PLL_WAIT: begin
        if (lock_done) begin
          next_state = ST_RUN;
          next_count = 32'h0;
        end
      end
      ST_RUN: begin
        next_count = 32'h0;
        if (supply_fail) begin
          next_state = ST_PARK;
        end
      end
      ST_PARK: begin
        if (park_done) begin
          next_state = ST_OFF;
          next_count = 32'h0;
        end
      end
      default: begin
        next_state = ST_OFF;
        next_count = 32'h0;
      end
    endcase
    // losing power_on_sense always drops back to full reset
    if (!sense_high) begin
      next_state = ST_OFF;
      next_count = 32'h0;
    end
  end

  always_comb begin
    next_mode = mode;
    if (state != ST_RUN) begin
      next_mode = MODE_STANDBY;
    end else if (mode_cmd_i.valid) begin
      next_mode = mode_cmd_i.mode;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= ST_OFF;
      count <= 32'h0;
      mode <= MODE_STANDBY;
    end else begin
      state <= next_state;
      count <= next_count;
      mode <= next_mode;
    end
  end

  // **********************************************************
  // domain controls
  // **********************************************************
  // processor side stays up through park so it can watch the array settle
  function automatic logic cpu_side_up(input seq_state_t s);
    cpu_side_up = (s == ST_RUN) || (s == ST_PARK);
  endfunction

  wire logic in_run = (state == ST_RUN);
  wire logic cpu_up = cpu_side_up(state);
  wire logic is_active = in_run && (mode == MODE_ACTIVE);
  // true only in the cycle before cpu_run rises, so the mark lines up with it
  wire logic boot_start = cpu_up && !domain_ctrl_o.cpu_run;
  domain_ctrl_t next_ctrl;

  assign next_ctrl.pins_oe_n = !cpu_up;
  assign next_ctrl.primary_pll_run = (state != ST_OFF);
  assign next_ctrl.cpu_run = cpu_up;
  assign next_ctrl.periph_run = cpu_up;
  assign next_ctrl.video_run = is_active;
  assign next_ctrl.mirror_array_run = is_active;

  // **********************************************************
  // registered outputs
  // **********************************************************
  // reset leaves pins floating until the sequence runs and the array parked until active mode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      domain_ctrl_o <= '{default: 1'b0, pins_oe_n: 1'b1};
      mirror_array_park_o <= 1'b1;
    end else begin
      domain_ctrl_o <= next_ctrl;
      mirror_array_park_o <= !is_active;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cpu_booting_o <= 1'b0;
      mode_o <= MODE_STANDBY;
    end else begin
      cpu_booting_o <= boot_start;
      mode_o <= mode;
    end
  end

endmodule // display_ctrl_power_mode_sequencer

`default_nettype wire

// ### design/pwr_seq_pkg.sv
// constants and types for the power-up and mode sequencer
// **********************************************************
// Notes on behaviour
// - two modes, standby and active, changed only by a host command. the code also forces standby whenever the sequencer is not in ST_RUN.
// - standby runs only processor and peripherals; mirror array parked, no image.
// - active enables every functional block for internal or external video.
// - while power_on_sense is low, every pin is high impedance.
// - rising power_on_sense releases primary_pll reset; all else stays in reset.
// - rest of logic held a further 60 ms for pll lock.
// - after 60 ms the processor resets release and boot begins.
// - after any reset: normal power, processor running, other blocks held. the code stays off after the warning reset until rst_n_i or a new sense_rise.
// - power_good_warning low parks mirror array, then resets the system.
// **********************************************************
package pwr_seq_pkg;

  localparam int unsigned CLOCK_MHZ = 250;
  localparam int unsigned PLL_LOCK_MS = 60;
  localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned PARK_CYCLES_DEFAULT = 16;
  localparam logic [1:0] SYNC_RESET_VALUE = 2'h0;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_PLL_WAIT,
    ST_RUN,
    ST_PARK
  } seq_state_t;

  typedef enum logic {
    MODE_STANDBY,
    MODE_ACTIVE
  } func_mode_t;

  // host command carrier
  typedef struct packed {
    logic valid;
    func_mode_t mode;
  } mode_cmd_t;

  // block enables and reset releases
  typedef struct packed {
    logic primary_pll_run;
    logic cpu_run;
    logic periph_run;
    logic video_run;
    logic mirror_array_run;
    logic pins_oe_n;
  } domain_ctrl_t;

endpackage : pwr_seq_pkg

// ### verif/mirror_array_model.sv
// mirror array driver model: reports parked a few cycles after a park request
`timescale 1ns/1ps
`default_nettype none
module mirror_array_model (
  input wire logic clock_i,
  input wire logic park_i,
  output logic parked_o
);
  // settling takes time, so parked never follows park in the same cycle
  logic [2:0] dly = 3'h0;
  always_ff @(posedge clock_i) begin
    dly <= {dly[1:0], park_i};
  end
  assign parked_o = dly[2];
endmodule // mirror_array_model
`default_nettype wire

// ### verif/pwr_seq_assertions.sv
// port checker for the power and mode sequencer
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_checker
  import pwr_seq_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic power_on_sense_i,
  input wire logic power_good_warning_n_i,
  input wire mode_cmd_t mode_cmd_i,
  input wire domain_ctrl_t domain_ctrl_o,
  input wire logic mirror_array_park_o,
  input wire func_mode_t mode_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_pins_float: assert property (!power_on_sense_i [*6] |-> domain_ctrl_o.pins_oe_n)
    else $error("pins driven with sense low");
  a_pll_first: assert property ($rose(domain_ctrl_o.primary_pll_run) |->
    $past(power_on_sense_i, 3) && !domain_ctrl_o.cpu_run) else $error("bad pll release");
  a_lock_hold: assert property ($rose(domain_ctrl_o.primary_pll_run) |=>
    !domain_ctrl_o.cpu_run [*8]) else $error("cpu released early");
  a_boot_order: assert property (domain_ctrl_o.cpu_run |->
    domain_ctrl_o.primary_pll_run && domain_ctrl_o.periph_run) else $error("boot order");
  a_standby_park: assert property (mode_o == MODE_STANDBY |->
    !domain_ctrl_o.video_run && mirror_array_park_o) else $error("standby not parked");
  a_active_run: assert property (mode_o == MODE_ACTIVE && !mirror_array_park_o |->
    domain_ctrl_o.video_run && domain_ctrl_o.mirror_array_run) else $error("active off");
  a_mode_cmd: assert property ($rose(mode_o) |-> $past(mode_cmd_i.valid, 2))
    else $error("mode without command");
  a_supply_park: assert property (!power_good_warning_n_i [*6] |->
    mirror_array_park_o && !domain_ctrl_o.video_run) else $error("no park on warning");
endmodule // pwr_seq_checker
bind display_ctrl_power_mode_sequencer pwr_seq_checker u_chk (.clock_i, .rst_n_i,
  .power_on_sense_i, .power_good_warning_n_i, .mode_cmd_i, .domain_ctrl_o,
  .mirror_array_park_o, .mode_o);
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the power and mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pwr_seq_pkg::*;
  localparam int unsigned LOCK = 20;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sense = 1'b0;
  logic warn_n = 1'b1;
  mode_cmd_t cmd = '0;
  logic parked;
  logic park;
  logic booting;
  domain_ctrl_t ctrl;
  func_mode_t mode;
  func_mode_t exp_mode;
  int num_errors = 0;
  int checked = 0;
  int n;
  always #2 clock_i = ~clock_i;
  display_ctrl_power_mode_sequencer #(.LOCK_CYCLES(LOCK), .PARK_CYCLES(16)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .power_on_sense_i(sense),
    .power_good_warning_n_i(warn_n), .mode_cmd_i(cmd), .mirror_array_parked_i(parked),
    .domain_ctrl_o(ctrl), .mirror_array_park_o(park), .mode_o(mode), .cpu_booting_o(booting));
  mirror_array_model partner (.clock_i(clock_i), .park_i(park), .parked_o(parked));
  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clock_i);
  endtask
  task automatic finish_test();
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(11));
    step(8);
    @(posedge clock_i) rst_n_i <= 1'b1;
    @(posedge clock_i) cmd <= '{valid: 1'b1, mode: MODE_ACTIVE};
    @(posedge clock_i) cmd <= '0;
    step(3);
    chk("off", 3'h2, {ctrl.primary_pll_run, ctrl.pins_oe_n, mode});
    // sense rises only once the supplies are up
    @(posedge clock_i) sense <= 1'b1;
    for (n = 0; ctrl.primary_pll_run !== 1'b1 && n < 50; n++) step(1);
    chk("cpu_run", 3'h0, ctrl.cpu_run);
    for (n = 0; ctrl.cpu_run !== 1'b1 && n < 200; n++) step(1);
    chk("lock_wait", 3'h1, n >= LOCK);
    chk("booting", 3'h1, booting);
    chk("boot", 3'h4, {ctrl.periph_run, ctrl.pins_oe_n, ctrl.video_run});
    step(1);
    chk("boot_mark_end", 3'h0, booting);
    exp_mode = MODE_STANDBY;
    repeat (30) begin
      // back-to-back pairs: the later valid command must win
      for (int i = 0; i < 2; i++) begin
        @(posedge clock_i) cmd <= mode_cmd_t'(2'($urandom_range(3)));
        #1 if (cmd.valid) exp_mode = cmd.mode;
      end
      @(posedge clock_i) cmd <= '0;
      step(3);
      chk("mode", {exp_mode, exp_mode, exp_mode == MODE_STANDBY},
        {mode, ctrl.video_run, park});
    end
    @(posedge clock_i) warn_n <= 1'b0;
    for (n = 0; ctrl.pins_oe_n !== 1'b1 && n < 100; n++) step(1);
    chk("shutdown", 3'h1, {ctrl.cpu_run, ctrl.video_run, park});
    // second reset after the warning shutdown with the pin still high: all off, then a fresh boot
    @(posedge clock_i) rst_n_i <= 1'b0;
    warn_n <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    step(1);
    chk("rst2", 3'h2, {ctrl.primary_pll_run, ctrl.pins_oe_n, mode});
    for (n = 0; ctrl.cpu_run !== 1'b1 && n < 200; n++) step(1);
    chk("reboot", 3'h4, {ctrl.periph_run, ctrl.pins_oe_n, ctrl.video_run});
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
